// >>> bench/ieps_chk_sva.sv
// ieps_chk_sva.sv: port-level checker for the enable/pending bank.
// assumes one clock, synchronous active-high reset, classic wishbone.
`timescale 1ns/1ps
module ieps_chk (
  input wire        CLK_SYS,
  input wire        SRST,
  input wire        WB_WE_I,
  input wire [31:0] WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire [30:0] IRQ_REQ,
  input wire [30:0] IRQ_ENABLE,
  input wire [30:0] IRQ_PENDING
);
  localparam [31:0] SE = 32'he000e100, CE = 32'he000e180, SP = 32'he000e200, CP = 32'he000e280;
  wire [31:0] bm   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [30:0] m    = WB_DAT_I[30:0] & bm[30:0];
  wire        wr   = WB_ACK_O && WB_WE_I;
  wire        rd   = WB_ACK_O && !WB_WE_I;
  wire        a_se = WB_ADR_I[31:2] == SE[31:2];
  wire        a_ce = WB_ADR_I[31:2] == CE[31:2];
  wire        a_sp = WB_ADR_I[31:2] == SP[31:2];
  wire        a_cp = WB_ADR_I[31:2] == CP[31:2];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  //////////////////////////////////////////
  set_en_a: assert property (wr && a_se |=>
    IRQ_ENABLE == ($past(IRQ_ENABLE) | $past(m))) else $error("set-enable write wrong");
  clr_en_a: assert property (wr && a_ce |=>
    IRQ_ENABLE == ($past(IRQ_ENABLE) & ~$past(m))) else $error("clear-enable write wrong");
  set_pend_a: assert property (wr && a_sp |=>
    IRQ_PENDING == ($past(IRQ_PENDING) | $past(m) | $past(IRQ_REQ))) else $error("set-pending write wrong");
  pend_keep_a: assert property (!(wr && a_cp) |=>
    ($past(IRQ_PENDING) & ~IRQ_PENDING) == 31'h0) else $error("pending bit dropped");
  req_sets_a: assert property (1'b1 |=>
    (IRQ_PENDING & $past(IRQ_REQ)) == $past(IRQ_REQ)) else $error("request did not set pending");
  en_source_a: assert property (IRQ_ENABLE != $past(IRQ_ENABLE) |->
    $past(wr && (a_se || a_ce)) || $past(SRST)) else $error("enable changed without write");
  rd_en_a: assert property (rd && (a_se || a_ce) |->
    WB_DAT_O == {1'b0, $past(IRQ_ENABLE)}) else $error("enable readback wrong");
  rd_pend_a: assert property (rd && (a_sp || a_cp) |->
    WB_DAT_O == {1'b0, $past(IRQ_PENDING)}) else $error("pending readback wrong");
  cover property (wr && a_ce);
  cover property (rd && a_sp);
  cover property (wr && a_cp && |IRQ_REQ);
endmodule // ieps_chk
bind ieps_core ieps_chk u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .IRQ_REQ(IRQ_REQ), .IRQ_ENABLE(IRQ_ENABLE), .IRQ_PENDING(IRQ_PENDING));

// >>> bench/ieps_src.sv
// ieps_src.sv: peripheral request sources feeding the pending bits.
// assumes level requests, sampled on the rising edge.
`timescale 1ns/1ps
module ieps_src (
  input  wire         clk,
  input  wire         srst,
  input  wire         go,
  output logic [30:0] req
);
  initial req = 31'h0;
  // sparse bits, so software clears are not always overridden
  always @(posedge clk)
    if (srst || !go) req <= 31'h0;
    else req <= 31'($urandom & $urandom & $urandom);
endmodule // ieps_src

// >>> bench/tb_top.sv
// tb_top.sv: self-checking bench for the enable/pending bank.
// assumes the design under hw/ and the source model beside it.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        CLK_SYS = 0, SRST = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic [31:0] adr = 0, dat = 0, q;
  logic [3:0]  sel = 0;
  logic [30:0] en_m = 0, pe_m = 0, en_d = 0, pe_d = 0;
  wire  [31:0] dat_o;
  wire         ack;
  wire  [30:0] req, en, pe, rdy;
  int          mismatches = 0, checks = 0;
  localparam logic [31:0] MAP [5] = '{32'he000e100, 32'he000e180, 32'he000e200, 32'he000e280, 32'he000e184};
  always #20 CLK_SYS = ~CLK_SYS;
  ieps_core u_dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ_REQ(req),
    .IRQ_ENABLE(en), .IRQ_PENDING(pe), .IRQ_READY(rdy));
  ieps_src u_src (.clk(CLK_SYS), .srst(SRST), .go(go), .req(req));
  wire  [31:0] bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  wire  [30:0] m  = dat[30:0] & bm[30:0];
  //////////////////////////////////////////
  // shadow bank; the _d copies match the read sampled one edge early
  always @(posedge CLK_SYS) begin
    en_d <= en_m;
    pe_d <= pe_m;
    if (SRST) begin
      en_m <= 0;
      pe_m <= 0;
    end else begin
      pe_m <= pe_m | req;
      if (ack === 1'b1 && we) case (adr)
        MAP[0]: en_m <= en_m | m;
        MAP[1]: en_m <= en_m & ~m;
        MAP[2]: pe_m <= pe_m | m | req;
        MAP[3]: pe_m <= (pe_m & ~m) | req;
        default: ;
      endcase
    end
  end
  function automatic [31:0] rexp(input [31:0] a);
    rexp = (a == MAP[0] || a == MAP[1]) ? {1'b0, en_d} : (a == MAP[2] || a == MAP[3]) ? {1'b0, pe_d} : 32'h0;
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge CLK_SYS); while (ack !== 1'b1 && ++n < 20);
    if (n >= 20) mismatches++;
    q = dat_o;
    if (!w) `CHK(q, rexp(a))
    cyc <= 0;
    stb <= 0;
    @(posedge CLK_SYS);
    `CHK(en, en_m)
    `CHK(pe, pe_m)
    `CHK(rdy, en_m & pe_m)
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #800000;
    mismatches++;
    wrap_up;
  end
  initial begin
    void'($urandom(49));
    repeat (3) @(posedge CLK_SYS);
    SRST <= 0;
    @(posedge CLK_SYS);
    foreach (MAP[i]) bus(0, MAP[i], 0, 0);
    bus(1, MAP[0], 32'hffffffff, 4'hf);
    bus(0, MAP[1], 0, 0);
    bus(1, MAP[1], 32'h40000001, 4'h9);
    bus(1, MAP[2], 32'hffffffff, 4'hf);
    bus(1, MAP[1], 32'hffffffff, 4'hf);
    go <= 1;
    repeat (80) bus(1'($urandom), MAP[$urandom % 5], $urandom, 4'($urandom));
    go <= 0;
    bus(1, MAP[3], 32'hffffffff, 4'hf);
    bus(0, MAP[2], 0, 0);
    wrap_up;
  end
endmodule // tb_top

// >>> hw/ieps_core.v
// ieps_core.v: enable and pending storage for the peripheral
// interrupt lines, with the set-enable, clear-enable, set-pending
// and clear-pending registers on a classic Wishbone slave.
// assumes a single-clock system, a master that holds a request
// until it sees ack, and request inputs synchronous to CLK_SYS.
`timescale 1ns/1ps
`include "ieps_regs.vh"

module ieps_core (
  input  wire                        CLK_SYS,
  input  wire                        SRST,
  input  wire                        WB_CYC_I,
  input  wire                        WB_STB_I,
  input  wire                        WB_WE_I,
  input  wire [`IEPS_ADR_W-1:0]      WB_ADR_I,
  input  wire [`IEPS_SEL_W-1:0]      WB_SEL_I,
  input  wire [`IEPS_DAT_W-1:0]      WB_DAT_I,
  output wire [`IEPS_DAT_W-1:0]      WB_DAT_O,
  output wire                        WB_ACK_O,
  input  wire [`IEPS_NUM_LINES-1:0]  IRQ_REQ,
  output wire [`IEPS_NUM_LINES-1:0]  IRQ_ENABLE,
  output wire [`IEPS_NUM_LINES-1:0]  IRQ_PENDING,
  output wire [`IEPS_NUM_LINES-1:0]  IRQ_READY
);

////////////////////////////////////////////////////////////////////
// bus handshake states

localparam [0:0] ST_IDLE = 1'b0;
localparam [0:0] ST_ACK  = 1'b1;

////////////////////////////////////////////////////////////////////
// decoding helpers

// word match: low address bits are ignored, every word is aligned
function word_hit;
  input [`IEPS_ADR_W-1:0] adr;
  input [`IEPS_ADR_W-1:0] base_adr;
  begin
    word_hit = (adr[`IEPS_ADR_W-1:`IEPS_ADR_WORD_LSB] ==
                base_adr[`IEPS_ADR_W-1:`IEPS_ADR_WORD_LSB]);
  end
endfunction

// expand byte enables to a bit mask
function [`IEPS_DAT_W-1:0] lane_mask;
  input [`IEPS_SEL_W-1:0] sel;
  begin
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  end
endfunction

// ones written into the line field, reserved bit dropped
function [`IEPS_NUM_LINES-1:0] line_ones;
  input [`IEPS_DAT_W-1:0] dat;
  input [`IEPS_SEL_W-1:0] sel;
  reg   [`IEPS_DAT_W-1:0] m;
  begin
    m         = dat & lane_mask(sel);
    line_ones = m[`IEPS_LINE_LAST:`IEPS_LINE_FIRST];
  end
endfunction

////////////////////////////////////////////////////////////////////
// state

reg  [0:0]                 state_r;
reg  [0:0]                 state_nxt;
reg                        ack_r;
reg                        ack_nxt;
reg  [`IEPS_DAT_W-1:0]     dat_r;
reg  [`IEPS_DAT_W-1:0]     dat_nxt;
reg  [`IEPS_NUM_LINES-1:0] enable_r;
wire [`IEPS_NUM_LINES-1:0] enable_nxt;
reg  [`IEPS_NUM_LINES-1:0] pending_r;
wire [`IEPS_NUM_LINES-1:0] pending_nxt;
reg  [`IEPS_NUM_LINES-1:0] ready_r;

////////////////////////////////////////////////////////////////////
// address decode

wire req_on;
wire hit_en_set;
wire hit_en_clr;
wire hit_pd_set;
wire hit_pd_clr;
wire hit_any;

assign req_on     = WB_CYC_I & WB_STB_I;
assign hit_en_set = word_hit(WB_ADR_I, `IEPS_ADR_ENABLE_SET);
assign hit_en_clr = word_hit(WB_ADR_I, `IEPS_ADR_ENABLE_CLEAR);
assign hit_pd_set = word_hit(WB_ADR_I, `IEPS_ADR_PENDING_SET);
assign hit_pd_clr = word_hit(WB_ADR_I, `IEPS_ADR_PENDING_CLR);
assign hit_any    = hit_en_set | hit_en_clr | hit_pd_set | hit_pd_clr;

////////////////////////////////////////////////////////////////////
// write strobes
// a write lands only on the edge where the master sees ack,
// so a master that abandons the cycle early changes nothing

wire wr_fire;
wire [`IEPS_NUM_LINES-1:0] wr_ones;
wire [`IEPS_NUM_LINES-1:0] en_set_bits;
wire [`IEPS_NUM_LINES-1:0] en_clr_bits;
wire [`IEPS_NUM_LINES-1:0] pd_set_bits;
wire [`IEPS_NUM_LINES-1:0] pd_clr_bits;

assign wr_fire     = (state_r == ST_ACK) & req_on & WB_WE_I;
assign wr_ones     = line_ones(WB_DAT_I, WB_SEL_I);
assign en_set_bits = (wr_fire & hit_en_set) ? wr_ones :
                     {`IEPS_NUM_LINES{1'b0}};
assign en_clr_bits = (wr_fire & hit_en_clr) ? wr_ones :
                     {`IEPS_NUM_LINES{1'b0}};
assign pd_set_bits = (wr_fire & hit_pd_set) ? wr_ones :
                     {`IEPS_NUM_LINES{1'b0}};
assign pd_clr_bits = (wr_fire & hit_pd_clr) ? wr_ones :
                     {`IEPS_NUM_LINES{1'b0}};

////////////////////////////////////////////////////////////////////
// per-line storage update

genvar i;
generate
  for (i = 0; i < `IEPS_NUM_LINES; i = i + 1) begin : g_line
    // zero bits fall through unchanged
    assign enable_nxt[i] = en_set_bits[i] |
                           (enable_r[i] & ~en_clr_bits[i]);
    // set beats clear so no request edge is lost
    assign pending_nxt[i] = pd_set_bits[i] |
                            IRQ_REQ[i] |
                            (pending_r[i] & ~pd_clr_bits[i]);
  end
endgenerate

// one shared enable vector behind both enable registers
always @(posedge CLK_SYS) begin
  if (SRST) begin
    enable_r <= `IEPS_ENABLE_RST;
  end else begin
    enable_r <= enable_nxt;
  end
end

// one shared pending vector behind both pending registers
always @(posedge CLK_SYS) begin
  if (SRST) begin
    pending_r <= `IEPS_PENDING_RST;
  end else begin
    pending_r <= pending_nxt;
  end
end

// lines both pending and enabled, for the priority stage
always @(posedge CLK_SYS) begin
  if (SRST) begin
    ready_r <= `IEPS_READY_RST;
  end else begin
    ready_r <= pending_nxt & enable_nxt;
  end
end

////////////////////////////////////////////////////////////////////
// read data
// both enable words show the same vector, both pending words too

reg [`IEPS_DAT_W-1:0] rd_val;

always @* begin
  rd_val = `IEPS_UNMAPPED_VAL;
  if (hit_en_set | hit_en_clr) begin
    rd_val = {`IEPS_RSVD_VAL, enable_r};
  end else if (hit_pd_set | hit_pd_clr) begin
    rd_val = {`IEPS_RSVD_VAL, pending_r};
  end
end

////////////////////////////////////////////////////////////////////
// bus handshake
// ack comes one cycle after the request and lasts one cycle;
// read data is captured then and held through the ack cycle

always @* begin
  state_nxt = state_r;
  ack_nxt   = 1'b0;
  dat_nxt   = dat_r;
  case (state_r)
    ST_IDLE: begin
      if (req_on) begin
        state_nxt = ST_ACK;
        ack_nxt   = 1'b1;
        // writes read back zero, unmapped words too
        if (!WB_WE_I && hit_any) begin
          dat_nxt = rd_val;
        end else begin
          dat_nxt = `IEPS_UNMAPPED_VAL;
        end
      end
    end
    ST_ACK: begin
      // ack always drops here, giving the master its idle cycle
      state_nxt = ST_IDLE;
      ack_nxt   = 1'b0;
    end
    default: begin
      state_nxt = ST_IDLE;
      ack_nxt   = 1'b0;
      dat_nxt   = `IEPS_DAT_RST;
    end
  endcase
end

always @(posedge CLK_SYS) begin
  if (SRST) begin
    state_r <= ST_IDLE;
    ack_r   <= 1'b0;
    dat_r   <= `IEPS_DAT_RST;
  end else begin
    state_r <= state_nxt;
    ack_r   <= ack_nxt;
    dat_r   <= dat_nxt;
  end
end

////////////////////////////////////////////////////////////////////
// outputs

// ack is masked if the master has let go, so a late ack never
// answers a request that is no longer there
assign WB_ACK_O    = ack_r & req_on;
assign WB_DAT_O    = dat_r;
assign IRQ_ENABLE  = enable_r;
assign IRQ_PENDING = pending_r;
assign IRQ_READY   = ready_r;

endmodule // ieps_core

// >>> hw/ieps_regs.vh
// ieps_regs.vh: address map, field positions and reset values
// of the interrupt enable / pending register bank.
// assumes a 32-bit byte-addressed bus with word-aligned registers.
`ifndef IEPS_REGS_VH
`define IEPS_REGS_VH

// number of peripheral interrupt lines
`define IEPS_NUM_LINES        31

// bus widths
`define IEPS_ADR_W            32
`define IEPS_DAT_W            32
`define IEPS_SEL_W            4

// register byte addresses
`define IEPS_ADR_ENABLE_SET   32'he000e100
`define IEPS_ADR_ENABLE_CLEAR 32'he000e180
`define IEPS_ADR_PENDING_SET  32'he000e200
`define IEPS_ADR_PENDING_CLR  32'he000e280

// word index starts at this address bit
`define IEPS_ADR_WORD_LSB     2

// field positions
`define IEPS_LINE_FIRST       0
`define IEPS_LINE_LAST        30
`define IEPS_USB_WAKE_BIT     30
`define IEPS_RSVD_BIT         31

// reset values
`define IEPS_ENABLE_RST       31'h00000000
`define IEPS_PENDING_RST      31'h00000000
`define IEPS_READY_RST        31'h00000000
`define IEPS_DAT_RST          32'h00000000

// value returned for reserved bits and unmapped words
`define IEPS_RSVD_VAL         1'b0
`define IEPS_UNMAPPED_VAL     32'h00000000

`endif
